// *** include/gpx_pkg.sv ***
// Constants, state encodings and carrier structs of the four-pin expander.
// Assumes a 100 MHz core clock and a bus of two open-drain lines.
package gpx_pkg;

	// ************************************************************
	// Sizes, address and register defaults
	// ************************************************************
	localparam int GPIO_N = 4;
	localparam logic [6:0] DEV_ADDR = 7'h41;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] PTR_IN = 2'h0;
	localparam logic [1:0] PTR_OUT = 2'h1;
	localparam logic [1:0] PTR_INV = 2'h2;
	localparam logic [1:0] PTR_DIR = 2'h3;
	localparam logic [3:0] IN_UPPER = 4'hF;
	localparam logic [7:0] OUT_RST = 8'hFF;
	localparam logic [7:0] INV_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [1:0] PTR_RST = 2'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 100;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] BUS_STABLE = 4'(SPIKE_CYC + 1);
	localparam logic [3:0] GPIO_STABLE = 4'h1;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_CMD = 4'h3,
		ST_CMD_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RD_ACK = 4'h8
	} gpx_state_t;

	typedef struct packed {
		gpx_state_t state;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [1:0] ptr;
		logic is_read;
		logic nack;
		logic sda_drive;
		logic scl_d;
		logic sda_d;
		logic [7:0] out;
		logic [7:0] inv;
		logic [7:0] dir;
	} gpx_core_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic level;
		logic [3:0] cnt;
	} gpx_filt_t;

	typedef struct packed {
		logic [GPIO_N-1:0] out;
		logic [GPIO_N-1:0] oe;
	} gpx_pin_drive_t;

endpackage

// *** rtl/gpx_expander.sv ***
// Two-wire bus target with four general-purpose pins behind four registers.
// Assumes sys_rst is the power-on reset and all pins are asynchronous.
// Function
// R1 - Answer only address 1000001; its lowest bit picks read (1) or write (0).
// R2 - First byte after a write address is the command byte, kept as pointer.
// R3 - Pointer 0..3 picks input, output, inversion or direction register.
// R4 - Input register shows every pin level, inputs and outputs alike.
// R5 - Writes to the input register change nothing.
// R6 - Input register upper four bits read one; lower four follow pins.
// R7 - Output bit drives its pin only while that pin is an output.
// R8 - Output register reads the stored value, not the pin level.
// R9 - Output register resets to all ones.
// R10 - Inversion bit set flips the matching input bit on reads.
// R11 - Inversion register resets to all zeros.
// R12 - Direction bit one makes pin an input; zero enables its driver.
// R13 - Direction register resets to all ones, so pins start as inputs.
// R14 - Reset holds the device and loads register and bus defaults.
// R15 - Spikes of at most 50 ns on both bus lines are suppressed.
// R16 - Pointer never advances; repeated reads hit the same register.
// R17 - Controller writes command, repeats start, reads, acknowledging all but last.
// R18 - Upper register bits have no pins; they are stored and read back.
`timescale 1ns/1ns
`default_nettype none
module gpx_expander
	import gpx_pkg::*;
(
	input wire logic core_clk, // Core clock, 100 MHz.
	input wire logic sys_rst, // Synchronous power-on reset.
	input wire logic scl_in, // Bus clock line level.
	input wire logic sda_in, // Bus data line level.
	output logic sda_out, // Bus data drive value, always low.
	output logic sda_oe, // Bus data pulls low when high.
	input wire logic [GPIO_N-1:0] port_pin_in, // Pin levels.
	output gpx_pin_drive_t port_pin_drv // Pin drive values and enables.
);

	gpx_core_t st;
	gpx_core_t next_st;
	logic scl_f;
	logic sda_f;
	logic [GPIO_N-1:0] pin_lvl;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic [7:0] rd_val;

	// ************************************************************
	// Input conditioning
	// ************************************************************
	gpx_line_filter #(.STABLE(BUS_STABLE), .RST_LEVEL(1'b1)) u_scl_filt (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_in(scl_in),
		.level(scl_f)
	);

	gpx_line_filter #(.STABLE(BUS_STABLE), .RST_LEVEL(1'b1)) u_sda_filt (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_in(sda_in),
		.level(sda_f)
	);

	genvar gi;
	generate
		for (gi = 0; gi < GPIO_N; gi++) begin : g_pin
			gpx_line_filter #(.STABLE(GPIO_STABLE), .RST_LEVEL(1'b1)) u_pin_filt (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.pin_in(port_pin_in[gi]),
				.level(pin_lvl[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Register read mux
	// ************************************************************
	function automatic logic [7:0] read_reg(input gpx_core_t s, input logic [GPIO_N-1:0] lvl);
		case (s.ptr)
			PTR_IN: read_reg = {IN_UPPER, lvl ^ s.inv[GPIO_N-1:0]}; // R4 R6 R10
			PTR_OUT: read_reg = s.out; // R8
			PTR_INV: read_reg = s.inv;
			PTR_DIR: read_reg = s.dir;
			default: read_reg = s.dir;
		endcase
	endfunction

	assign scl_rise = scl_f && !st.scl_d;
	assign scl_fall = !scl_f && st.scl_d;
	assign start_cond = scl_f && st.scl_d && st.sda_d && !sda_f;
	assign stop_cond = scl_f && st.scl_d && !st.sda_d && sda_f;
	assign byte_done = scl_fall && (st.bit_cnt == BYTE_BITS);
	assign rd_val = read_reg(st, pin_lvl); // R3

	// ************************************************************
	// Bus state machine
	// ************************************************************
	// Our own data changes only after a falling clock, so it never forms
	// a start or stop condition of its own.
	always_comb begin
		next_st = st;
		next_st.scl_d = scl_f;
		next_st.sda_d = sda_f;
		if (start_cond) begin
			next_st.state = ST_ADDR;
			next_st.bit_cnt = 4'h0;
			next_st.sda_drive = 1'b0;
		end else if (stop_cond) begin
			next_st.state = ST_IDLE;
			next_st.sda_drive = 1'b0;
		end else begin
			case (st.state)
				ST_IDLE: begin
					next_st.sda_drive = 1'b0;
				end
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (scl_rise) begin
						next_st.shift = {st.shift[6:0], sda_f};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end
					if (byte_done) begin
						next_st.sda_drive = 1'b1;
						if (st.state == ST_ADDR) begin
							if (st.shift[7:1] == DEV_ADDR) begin
								next_st.state = ST_ADDR_ACK; // R1
								next_st.is_read = st.shift[0]; // R1
								next_st.tx = rd_val; // R3
							end else begin
								next_st.state = ST_IDLE; // R1
								next_st.sda_drive = 1'b0;
							end
						end else if (st.state == ST_CMD) begin
							next_st.ptr = st.shift[1:0]; // R2
							next_st.state = ST_CMD_ACK;
						end else begin
							next_st.state = ST_WDATA_ACK;
							case (st.ptr)
								PTR_OUT: next_st.out = st.shift; // R18
								PTR_INV: next_st.inv = st.shift;
								PTR_DIR: next_st.dir = st.shift;
								default: next_st.out = st.out; // R5
							endcase
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						next_st.bit_cnt = 4'h0;
						if (st.is_read) begin
							next_st.state = ST_RDATA;
							next_st.sda_drive = !st.tx[7];
						end else begin
							next_st.state = ST_CMD; // R2
							next_st.sda_drive = 1'b0;
						end
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_st.bit_cnt = 4'h0;
						next_st.state = ST_WDATA;
						next_st.sda_drive = 1'b0;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end
					if (byte_done) begin
						next_st.state = ST_RD_ACK;
						next_st.sda_drive = 1'b0;
					end else if (scl_fall) begin
						next_st.tx = {st.tx[6:0], 1'b0};
						next_st.sda_drive = !st.tx[6];
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						next_st.nack = sda_f; // R17
					end
					if (scl_fall) begin
						if (!st.nack) begin
							next_st.state = ST_RDATA;
							next_st.tx = rd_val; // R16
							next_st.sda_drive = !rd_val[7];
							next_st.bit_cnt = 4'h0;
						end else begin
							next_st.state = ST_IDLE;
						end
					end
				end
				default: begin
					next_st.state = ST_IDLE;
					next_st.sda_drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '0; // R14
			st.state <= ST_IDLE; // R14
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.ptr <= PTR_RST;
			st.out <= OUT_RST; // R9
			st.inv <= INV_RST; // R11
			st.dir <= DIR_RST; // R13
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign sda_out = 1'b0;
	assign sda_oe = st.sda_drive;
	assign port_pin_drv.out = st.out[GPIO_N-1:0]; // R7
	assign port_pin_drv.oe = ~st.dir[GPIO_N-1:0]; // R12

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_addr_done;
		st.state == ST_ADDR && byte_done;
	endsequence

	sequence s_cmd_done;
		st.state == ST_CMD && byte_done;
	endsequence

	sequence s_wr_done;
		st.state == ST_WDATA && byte_done;
	endsequence

	sequence s_read_entry;
		st.state == ST_ADDR_ACK && st.is_read && $past(st.state) == ST_ADDR;
	endsequence

	a_addr_mismatch: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		s_addr_done ##0 (st.shift[7:1] != DEV_ADDR) |=> !sda_oe [*2] ##0 st.state == ST_IDLE)
		else $error("Foreign address was answered.");

	a_addr_match: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		s_addr_done ##0 (st.shift[7:1] == DEV_ADDR) ##0 !start_cond ##0 !stop_cond
		|=> sda_oe && st.is_read == $past(st.shift[0]))
		else $error("Own address was not acknowledged.");

	a_cmd_pointer: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		s_cmd_done ##0 !start_cond ##0 !stop_cond |=> st.ptr == $past(st.shift[1:0]))
		else $error("Command byte not stored as pointer.");

	a_read_dir: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		s_read_entry ##0 (st.ptr == PTR_DIR) |-> st.tx == st.dir)
		else $error("Read of direction register returned wrong data.");

	a_input_value: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		s_read_entry ##0 (st.ptr == PTR_IN)
		|-> st.tx == {IN_UPPER, $past(pin_lvl) ^ st.inv[GPIO_N-1:0]})
		else $error("Input register read mismatch.");

	a_input_wr_ignored: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		s_wr_done ##0 (st.ptr == PTR_IN)
		|=> st.out == $past(st.out) && st.inv == $past(st.inv) && st.dir == $past(st.dir))
		else $error("Write to input register changed state.");

	a_out_write: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		s_wr_done ##0 (st.ptr == PTR_OUT) ##0 !start_cond ##0 !stop_cond
		|=> port_pin_drv.out == $past(st.shift[GPIO_N-1:0]) && st.out == $past(st.shift))
		else $error("Output write did not reach the pins.");

	a_dir_write: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
		s_wr_done ##0 (st.ptr == PTR_DIR) ##0 !start_cond ##0 !stop_cond
		|=> port_pin_drv.oe == ~$past(st.shift[GPIO_N-1:0]))
		else $error("Direction write did not set drivers.");

	a_reset_defaults: assert property (@(posedge core_clk) // R14
		sys_rst |=> st.out == OUT_RST && st.inv == INV_RST && st.dir == DIR_RST
		&& st.state == ST_IDLE && !sda_oe)
		else $error("Reset defaults not loaded.");

	a_ptr_fixed: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
		$changed(st.ptr) |-> $past(st.state) == ST_CMD)
		else $error("Pointer changed outside a command byte.");

	a_read_first_bit: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		st.state == ST_ADDR_ACK && st.is_read && scl_fall && !start_cond && !stop_cond
		|=> st.state == ST_RDATA && sda_oe == !st.tx[7])
		else $error("First read bit not driven from the selected register.");

	a_read_repeat: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
		st.state == ST_RD_ACK && scl_fall && !st.nack && !start_cond && !stop_cond
		|=> st.state == ST_RDATA && st.ptr == $past(st.ptr) && st.tx == $past(rd_val))
		else $error("Repeated read did not reload the same register.");

	a_ack_release: assert property (@(posedge core_clk) disable iff (sys_rst) // R17
		st.state == ST_RDATA && byte_done && !start_cond && !stop_cond
		|=> st.state == ST_RD_ACK && !sda_oe)
		else $error("Data line not released for the controller acknowledge.");

endmodule
`default_nettype wire

// *** rtl/gpx_line_filter.sv ***
// Two-stage synchroniser followed by a spike filter for one pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module gpx_line_filter
	import gpx_pkg::*;
#(
	parameter logic [3:0] STABLE = BUS_STABLE,
	parameter logic RST_LEVEL = 1'b1
) (
	input wire logic core_clk, // Core clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic pin_in, // Raw pin level.
	output logic level // Filtered level.
);

	gpx_filt_t st;
	gpx_filt_t next_st;

	// ************************************************************
	// Filter
	// ************************************************************
	// A new level is taken only after STABLE samples in a row disagree.
	always_comb begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		if (st.s2 == st.level) begin
			next_st.cnt = 4'h0;
		end else if (st.cnt == STABLE - 4'h1) begin
			next_st.level = st.s2; // R15
			next_st.cnt = 4'h0;
		end else begin
			next_st.cnt = st.cnt + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '{s1: RST_LEVEL, s2: RST_LEVEL, level: RST_LEVEL, cnt: 4'h0};
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;

	a_spike_reject: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
		$changed(st.level) |-> $past(st.cnt) == STABLE - 4'h1)
		else $error("Filtered level changed before the spike window elapsed.");

endmodule
`default_nettype wire

// *** verification/gpx_bus_ctrl.sv ***
// Two-wire bus controller model that drives the expander's bus lines.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module gpx_bus_ctrl (
	input wire logic core_clk, // Time base for all line changes.
	input wire logic sda_wire, // Resolved data line level.
	output logic scl, // Clock line, high and still between frames.
	output logic sda_low, // High pulls the data line low.
	input wire logic spike // High adds a short clock pulse in the low phase of each bit.
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// The low phase is long because the device answers about 100 ns after a fall.
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_low = ~b;
		tick(6);
		scl = spike;
		tick(4);
		scl = 1'b0;
		tick(12);
		scl = 1'b1;
		tick(8);
		r = sda_wire;
		scl = 1'b0;
	endtask
	task automatic start;
		if (!scl) begin
			tick(2);
			sda_low = 1'b0;
			tick(22);
			scl = 1'b1;
		end
		tick(16);
		sda_low = 1'b1;
		tick(16);
		scl = 1'b0;
	endtask
	task automatic stop;
		tick(2);
		sda_low = 1'b1;
		tick(22);
		scl = 1'b1;
		tick(16);
		sda_low = 1'b0;
		tick(16);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule
`default_nettype wire

// *** verification/i2c_four_bit_gpio_expander_bench.sv ***
// Self-checking bench for the four-pin expander, all access over the bus.
// Assumes the bus controller model gpx_bus_ctrl and pins with outside drivers.
`timescale 1ns/1ns
`default_nettype none
module i2c_four_bit_gpio_expander_bench;
	import gpx_pkg::*;
	logic core_clk, sys_rst, scl, sda_low, sda_out, sda_oe, sda_wire, spike, a;
	logic [3:0] pin_ext, port_pin_in;
	logic [7:0] d;
	gpx_pin_drive_t drv;
	int n_errors = 0;
	int check_count = 0;
	assign sda_wire = ~((sda_oe & ~sda_out) | sda_low);
	// Driven pins show the expander's level, the others the outside level.
	assign port_pin_in = (drv.oe & drv.out) | (~drv.oe & pin_ext);
	gpx_expander dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.port_pin_in(port_pin_in), .port_pin_drv(drv));
	gpx_bus_ctrl ctl (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
		.sda_low(sda_low), .spike(spike));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_ack(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: acknowledge got %b", $time, got);
		end
	endtask
	task automatic reg_wr(input logic [1:0] p, input logic [7:0] v);
		ctl.start();
		ctl.wr_byte({DEV_ADDR, 1'b0}, a);
		chk_ack(a, 1'b1);
		ctl.wr_byte({6'h00, p}, a);
		chk_ack(a, 1'b1);
		ctl.wr_byte(v, a);
		chk_ack(a, 1'b1);
		ctl.stop();
	endtask
	// Without a fresh command the kept pointer selects the register.
	task automatic reg_rd(input logic [1:0] p, input logic fresh, input logic [7:0] exp,
		input int n);
		if (fresh) begin
			ctl.start();
			ctl.wr_byte({DEV_ADDR, 1'b0}, a);
			ctl.wr_byte({6'h00, p}, a);
		end
		ctl.start();
		ctl.wr_byte({DEV_ADDR, 1'b1}, a);
		chk_ack(a, 1'b1);
		for (int k = 0; k < n; k++) begin
			ctl.rd_byte(k == n - 1, d);
			chk_byte(d, exp, "register");
		end
		ctl.stop();
	endtask
	task automatic chk_defaults;
		chk_byte({drv.out, drv.oe}, 8'hF0, "drive");
		reg_rd(PTR_OUT, 1'b1, OUT_RST, 1);
		reg_rd(PTR_INV, 1'b1, INV_RST, 1);
		reg_rd(PTR_DIR, 1'b1, DIR_RST, 1);
		reg_rd(PTR_IN, 1'b1, {IN_UPPER, pin_ext}, 1);
	endtask
	task automatic test_done(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge core_clk);
		n_errors++;
		finish_test();
	end
	initial begin
		sys_rst = 1'b1;
		pin_ext = 4'hA;
		spike = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		ctl.tick(20);
		chk_defaults();
		test_done("defaults");
		ctl.start();
		ctl.wr_byte(8'h84, a);
		chk_ack(a, 1'b0);
		ctl.stop();
		reg_wr(PTR_IN, 8'h55);
		reg_rd(PTR_IN, 1'b1, 8'hFA, 1);
		chk_byte({drv.out, drv.oe}, 8'hF0, "drive");
		test_done("address and input");
		reg_wr(PTR_INV, 8'hC6);
		reg_rd(PTR_INV, 1'b1, 8'hC6, 1);
		reg_rd(PTR_IN, 1'b1, 8'hFC, 1);
		spike = 1'b1;
		reg_wr(PTR_OUT, 8'h35);
		spike = 1'b0;
		chk_byte({4'h0, port_pin_in}, 8'h0A, "pins");
		reg_wr(PTR_DIR, 8'hF9);
		chk_byte({drv.out, drv.oe}, 8'h56, "drive");
		chk_byte({4'h0, port_pin_in}, 8'h0C, "pins");
		reg_rd(PTR_IN, 1'b1, 8'hFA, 1);
		reg_rd(PTR_DIR, 1'b1, 8'hF9, 1);
		reg_rd(PTR_OUT, 1'b1, 8'h35, 3);
		reg_rd(PTR_OUT, 1'b0, 8'h35, 2);
		test_done("registers and pins");
		sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		ctl.tick(20);
		chk_defaults();
		test_done("second reset");
		finish_test();
	end
endmodule
`default_nettype wire
